// ===== sdc_pkg.sv
// Package: register map, field layout and constants for the synthesizer divider config bank
package sdc_pkg;
   // -------------------------------------------------------------
   // Register indices and byte addresses
   // -------------------------------------------------------------
   localparam logic [3:0]  IDX_INT_CTRL  = 4'h0;
   localparam logic [3:0]  IDX_MAIN_FRAC = 4'h1;
   localparam logic [3:0]  IDX_AUX_FRAC  = 4'h2;
   localparam logic [3:0]  IDX_PHASE_CTL = 4'h3;
   // Status and shadow readback offsets
   localparam logic [11:0] ADDR_STATUS   = 12'h010;
   localparam logic [11:0] ADDR_LOAD_CNT = 12'h014;
   localparam logic [11:0] ADDR_SHADOW1  = 12'h018;
   localparam logic [11:0] ADDR_SHADOW2  = 12'h01c;

   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int SEL_LSB      = 0;
   localparam int SEL_W        = 4;
   localparam int CAL_EN_BIT   = 21;
   localparam int PRESC_BIT    = 20;
   localparam int INT_LSB      = 4;
   localparam int INT_W        = 16;
   localparam int MFRAC_LSB    = 4;
   localparam int MFRAC_W      = 24;
   localparam int AFRAC_LSB    = 18;
   localparam int AMOD_LSB     = 4;
   localparam int AUX_W        = 14;
   localparam int SD_RST_DIS_BIT = 30;

   // -------------------------------------------------------------
   // Reset value and shift register width
   // -------------------------------------------------------------
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam int          SHIFT_W  = 32;
endpackage : sdc_pkg

// ===== sdc_shift_in.sv
// Serial word receiver: MSB-first shift register with a load strobe
`timescale 1ns/100ps
`default_nettype none
module sdc_shift_in #(
   parameter int WIDTH = 32
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   // Synchronised serial inputs
   input  wire logic             serData,
   input  wire logic             serClkRise,
   input  wire logic             loadRise,
   // Word out
   output logic [WIDTH-1:0]      word_r,
   output logic                  wordValid
);
   logic [WIDTH-1:0] shift_r;

   // Word goes in MSB first
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         shift_r <= '0;
      end else if (serClkRise) begin
         shift_r <= {shift_r[WIDTH-2:0], serData}; // see [R20]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         word_r <= '0;
      end else if (loadRise) begin
         word_r <= shift_r;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         wordValid <= 1'b0;
      end else begin
         wordValid <= loadRise;
      end
   end
endmodule : sdc_shift_in
`default_nettype wire

// ===== sdc_config_regs.sv
// Top: configuration register bank, serial load path and APB mirror
//
// Overview of operation
// [R1] Select 0000 to control, 0001 main fraction
// [R2] Select 0010 aux fraction, 0011 phase control
// [R3] Host zeroes unused upper bits, words 0,1
// [R4] Host keeps bit 31 of word 3 zero
// [R5] Calibration enable set: word 0 starts calibration
// [R6] Calibration enable clear: keep current band
// [R7] Host clears calibration only for small steps
// [R8] Prescaler choice from word 0 bit 20
// [R9] Integer divide from word 0 bits 19:4
// [R10] Host: 4/5 prescaler integer 23..32767
// [R11] Host: 8/9 prescaler integer 75..65535
// [R12] Main numerator from word 1 bits 27:4
// [R13] Host keeps main numerator below denominator
// [R14] Fraction words shadowed until word 0 written
// [R15] Aux numerator from word 2 bits 31:18
// [R16] Aux denominator from word 2 bits 17:4
// [R17] Host keeps aux numerator below denominator
// [R18] Word 0 write resets modulator unless disabled
// [R19] Word 3 bit 30 disables modulator reset
// [R20] Word shifted MSB first, then load strobe
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
module sdc_config_regs (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // Serial programming pins
   input  wire logic        serClk,
   input  wire logic        serData,
   input  wire logic        loadEn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Synthesizer controls
   output logic [15:0]      intDivide,
   output logic             prescalerSelect,
   output logic             autocalEnable,
   output logic [23:0]      mainNumerator,
   output logic [13:0]      auxNumerator,
   output logic [13:0]      auxDenominator,
   output logic             modulatorResetDisable,
   output logic             calStart,
   output logic             modulatorReset
);
   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   logic [1:0] clkSync_r, datSync_r, ldSync_r;
   logic       clkPrev_r, ldPrev_r;
   logic       serClkRise, loadRise;
   logic [31:0] word;
   logic        wordValid;

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         clkSync_r <= 2'h0;
         datSync_r <= 2'h0;
         ldSync_r  <= 2'h0;
         clkPrev_r <= 1'b0;
         ldPrev_r  <= 1'b0;
      end else begin
         clkSync_r <= {clkSync_r[0], serClk};
         datSync_r <= {datSync_r[0], serData};
         ldSync_r  <= {ldSync_r[0], loadEn};
         clkPrev_r <= clkSync_r[1];
         ldPrev_r  <= ldSync_r[1];
      end
   end

   assign serClkRise = clkSync_r[1] & ~clkPrev_r;
   assign loadRise   = ldSync_r[1] & ~ldPrev_r;

   sdc_shift_in #(
      .WIDTH (sdc_pkg::SHIFT_W)
   ) u_shift (
      .sys_clk    (sys_clk),
      .resetn     (resetn),
      .serData    (datSync_r[1]),
      .serClkRise (serClkRise),
      .loadRise   (loadRise),
      .word_r     (word),
      .wordValid  (wordValid)
   );

   // -------------------------------------------------------------
   // Select decode
   // -------------------------------------------------------------
   logic [3:0] sel;
   logic       wr0, wr1, wr2, wr3;
   assign sel = word[sdc_pkg::SEL_LSB +: sdc_pkg::SEL_W];
   assign wr0 = wordValid && (sel == sdc_pkg::IDX_INT_CTRL);  // see [R1]
   assign wr1 = wordValid && (sel == sdc_pkg::IDX_MAIN_FRAC); // see [R1]
   assign wr2 = wordValid && (sel == sdc_pkg::IDX_AUX_FRAC);  // see [R2]
   assign wr3 = wordValid && (sel == sdc_pkg::IDX_PHASE_CTL); // see [R2]

   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   logic [31:0] intCtrl_r, phaseCtl_r;
   logic [31:0] mainShadow_r, auxShadow_r;
   logic [31:0] mainActive_r, auxActive_r;
   logic [15:0] loadCount_r;

   // Unused upper bits are stored as written; host keeps them zero (see [R3])
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         intCtrl_r <= sdc_pkg::RST_WORD;
      end else if (wr0) begin
         intCtrl_r <= word;
      end
   end

   // Bit 31 is not looked at; host keeps it zero (see [R4])
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         phaseCtl_r <= sdc_pkg::RST_WORD;
      end else if (wr3) begin
         phaseCtl_r <= word;
      end
   end

   // Shadow stage for the double-buffered words
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         mainShadow_r <= sdc_pkg::RST_WORD;
         auxShadow_r  <= sdc_pkg::RST_WORD;
      end else begin
         if (wr1) begin
            mainShadow_r <= word; // see [R14]
         end
         if (wr2) begin
            auxShadow_r <= word; // see [R14]
         end
      end
   end

   // Committed on a word 0 write; same-cycle shadow writes cannot collide
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         mainActive_r <= sdc_pkg::RST_WORD;
         auxActive_r  <= sdc_pkg::RST_WORD;
      end else if (wr0) begin
         mainActive_r <= mainShadow_r; // see [R14]
         auxActive_r  <= auxShadow_r;  // see [R14]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         loadCount_r <= 16'h0000;
      end else if (wr0) begin
         loadCount_r <= loadCount_r + 16'h0001;
      end
   end

   // -------------------------------------------------------------
   // Action pulses
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         calStart       <= 1'b0;
         modulatorReset <= 1'b0;
      end else begin
         calStart       <= wr0 && word[sdc_pkg::CAL_EN_BIT]; // see [R5] [R6]
         // Uses the stored word 3, so a disable takes effect at once
         modulatorReset <= wr0 && !phaseCtl_r[sdc_pkg::SD_RST_DIS_BIT]; // see [R18] [R19]
      end
   end

   // -------------------------------------------------------------
   // Field outputs
   // -------------------------------------------------------------
   assign intDivide       = intCtrl_r[sdc_pkg::INT_LSB +: sdc_pkg::INT_W];      // see [R9]
   assign prescalerSelect = intCtrl_r[sdc_pkg::PRESC_BIT];                      // see [R8]
   assign autocalEnable   = intCtrl_r[sdc_pkg::CAL_EN_BIT];
   assign mainNumerator   = mainActive_r[sdc_pkg::MFRAC_LSB +: sdc_pkg::MFRAC_W]; // see [R12]
   assign auxNumerator    = auxActive_r[sdc_pkg::AFRAC_LSB +: sdc_pkg::AUX_W];  // see [R15]
   assign auxDenominator  = auxActive_r[sdc_pkg::AMOD_LSB +: sdc_pkg::AUX_W];   // see [R16]
   assign modulatorResetDisable = phaseCtl_r[sdc_pkg::SD_RST_DIS_BIT];          // see [R19]

   // -------------------------------------------------------------
   // APB slave: read-only mirror, zero wait states
   // -------------------------------------------------------------
   logic        rdHit;
   logic [31:0] rdData;

   always_comb begin
      rdHit  = 1'b1;
      rdData = 32'h0000_0000;
      case (paddr)
         {6'h00, sdc_pkg::IDX_INT_CTRL, 2'h0}:  rdData = intCtrl_r;
         {6'h00, sdc_pkg::IDX_MAIN_FRAC, 2'h0}: rdData = mainActive_r;
         {6'h00, sdc_pkg::IDX_AUX_FRAC, 2'h0}:  rdData = auxActive_r;
         {6'h00, sdc_pkg::IDX_PHASE_CTL, 2'h0}: rdData = phaseCtl_r;
         sdc_pkg::ADDR_STATUS:   rdData = {29'h0, modulatorResetDisable,
                                           prescalerSelect, autocalEnable};
         sdc_pkg::ADDR_LOAD_CNT: rdData = {16'h0000, loadCount_r};
         sdc_pkg::ADDR_SHADOW1:  rdData = mainShadow_r;
         sdc_pkg::ADDR_SHADOW2:  rdData = auxShadow_r;
         default:                rdHit  = 1'b0;
      endcase
   end

   assign pready = 1'b1;

   // Writes are refused: registers are load-only from the serial port
   always_comb begin
      pslverr = psel && penable && (pwrite || !rdHit);
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rdData;
      end
   end

   // -------------------------------------------------------------
   // Assertions: serial path
   // -------------------------------------------------------------
   a_load_only_word: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R20]
      $changed(word)
      |-> $past(loadRise))
      else $error("received word changed without a load strobe");
   a_valid_after_load: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R20]
      loadRise
      |=> wordValid)
      else $error("load strobe did not flag a word");

   // -------------------------------------------------------------
   // Assertions: select decode and storage
   // -------------------------------------------------------------
   a_sel_zero_route: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R1]
      wr0
      |=> intCtrl_r == $past(word))
      else $error("word 0 not stored");
   a_sel_one_route: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R1]
      wr1
      |=> mainShadow_r == $past(word))
      else $error("word 1 not stored in its shadow");
   a_sel_two_route: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R2]
      wr2
      |=> auxShadow_r == $past(word))
      else $error("word 2 not stored in its shadow");
   a_sel_three_store: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R2]
      wr3
      |=> phaseCtl_r == $past(word))
      else $error("word 3 not stored");
   a_sel_three_route: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R2]
      wordValid && sel != sdc_pkg::IDX_PHASE_CTL
      |=> $stable(phaseCtl_r))
      else $error("phase word changed on other select");
   a_ctrl_hold: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R1]
      !wr0
      |=> $stable(intCtrl_r))
      else $error("word 0 changed on other select");
   a_main_sel_only: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R1]
      wordValid && sel != sdc_pkg::IDX_MAIN_FRAC
      |=> $stable(mainShadow_r))
      else $error("word 1 shadow changed on other select");
   a_aux_sel_only: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R2]
      wordValid && sel != sdc_pkg::IDX_AUX_FRAC
      |=> $stable(auxShadow_r))
      else $error("word 2 shadow changed on other select");

   // -------------------------------------------------------------
   // Assertions: commit and field outputs
   // -------------------------------------------------------------
   a_shadow_hold: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R14]
      !wr0
      |=> $stable(mainActive_r) && $stable(auxActive_r))
      else $error("active fraction changed without word 0");
   a_shadow_commit: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R14]
      wr0
      |=> mainActive_r == $past(mainShadow_r) && auxActive_r == $past(auxShadow_r))
      else $error("shadow not committed");
   a_int_field: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R9]
      wr0
      |=> intDivide == $past(word[sdc_pkg::INT_LSB +: sdc_pkg::INT_W]))
      else $error("integer field wrong");
   a_presc_field: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R8]
      wr0
      |=> prescalerSelect == $past(word[sdc_pkg::PRESC_BIT]))
      else $error("prescaler field wrong");
   a_main_field: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R12]
      wr0
      |=> mainNumerator == $past(mainShadow_r[sdc_pkg::MFRAC_LSB +: sdc_pkg::MFRAC_W]))
      else $error("main numerator field wrong");
   a_aux_num_field: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R15]
      wr0
      |=> auxNumerator == $past(auxShadow_r[sdc_pkg::AFRAC_LSB +: sdc_pkg::AUX_W]))
      else $error("aux numerator field wrong");
   a_aux_den_field: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R16]
      wr0
      |=> auxDenominator == $past(auxShadow_r[sdc_pkg::AMOD_LSB +: sdc_pkg::AUX_W]))
      else $error("aux denominator field wrong");
   a_load_count: assert property (@(posedge sys_clk) disable iff (!resetn)
      wr0
      |=> loadCount_r == $past(loadCount_r) + 16'h0001)
      else $error("word 0 load count not advanced");

   // -------------------------------------------------------------
   // Assertions: action pulses
   // -------------------------------------------------------------
   a_cal_start_cause: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R5]
      calStart
      |-> $past(wr0) && $past(word[sdc_pkg::CAL_EN_BIT]))
      else $error("calibration start without enabled word 0 write");
   a_cal_start_on: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R5]
      wr0 && word[sdc_pkg::CAL_EN_BIT]
      |=> calStart)
      else $error("calibration start missing");
   a_autocal_field: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R5]
      wr0
      |=> autocalEnable == $past(word[sdc_pkg::CAL_EN_BIT]))
      else $error("calibration enable field wrong");
   a_cal_suppressed: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R6]
      wr0 && !word[sdc_pkg::CAL_EN_BIT]
      |=> !calStart)
      else $error("calibration started while disabled");
   a_mod_reset_on: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R18]
      wr0 && !modulatorResetDisable
      |=> modulatorReset)
      else $error("modulator reset missing");
   a_mod_reset_cause: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R19]
      modulatorReset
      |-> $past(wr0) && !$past(modulatorResetDisable))
      else $error("modulator reset without enabled word 0 write");
   a_mod_reset_off: assert property (@(posedge sys_clk) disable iff (!resetn) // see [R19]
      modulatorResetDisable && $stable(phaseCtl_r)
      |-> !modulatorReset)
      else $error("modulator reset while disabled");

   // -------------------------------------------------------------
   // Assertions: register bus
   // -------------------------------------------------------------
   a_apb_ready: assert property (@(posedge sys_clk) disable iff (!resetn)
      psel && penable
      |-> pready)
      else $error("bus access not completed");
   a_apb_wr_refused: assert property (@(posedge sys_clk) disable iff (!resetn)
      psel && penable && pwrite
      |-> pslverr)
      else $error("bus write not refused");
   a_apb_rd_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
      !(psel && !penable && !pwrite)
      |=> $stable(prdata))
      else $error("read data changed outside a read setup");
endmodule : sdc_config_regs
`default_nettype wire

// ===== sdc_host_model.sv
// Host model: drives the serial programming pins of the config bank
`timescale 1ns/100ps
`default_nettype none
module sdc_host_model (
   // Clock
   input  wire logic sys_clk,
   // Serial programming pins
   output logic      serClk,
   output logic      serData,
   output logic      loadEn
);
   // Bit clock stands still low between frames
   initial begin
      serClk  = 1'b0;
      serData = 1'b0;
      loadEn  = 1'b0;
   end

   // One cycle is the shortest level the synchroniser accepts; send_word holds three
   task automatic hold_cycles(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : hold_cycles

   task automatic send_word(input logic [31:0] w);
      logic [31:0] v;
      v = w;
      if (v[3:0] == 4'h0) v[31:22] = 10'h000;
      if (v[3:0] == 4'h1) v[31:28] = 4'h0;
      if (v[3:0] == 4'h3) v[31] = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         serData <= v[i];
         hold_cycles(3);
         serClk <= 1'b1;
         hold_cycles(3);
         serClk <= 1'b0;
      end
      // Released data line shows the inverse, never a stale bit
      serData <= ~v[0];
      hold_cycles(3);
      loadEn <= 1'b1;
      hold_cycles(3);
      loadEn <= 1'b0;
      hold_cycles(3);
   endtask : send_word
endmodule : sdc_host_model
`default_nettype wire

// ===== tb.sv
// Testbench: serial loads through the host model, APB readback checks
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic        sys_clk, resetn, serClk, serData, loadEn;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] intDivide;
   logic        prescalerSelect, autocalEnable, modulatorResetDisable;
   logic        calStart, modulatorReset, err;
   logic [23:0] mainNumerator;
   logic [13:0] auxNumerator, auxDenominator;
   int          num_errors = 0, checked = 0, calCnt = 0, modCnt = 0;

   initial sys_clk = 1'b0;
   always #12.5 sys_clk = ~sys_clk;

   sdc_config_regs dut (.sys_clk(sys_clk), .resetn(resetn), .serClk(serClk),
      .serData(serData), .loadEn(loadEn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .intDivide(intDivide),
      .prescalerSelect(prescalerSelect), .autocalEnable(autocalEnable),
      .mainNumerator(mainNumerator), .auxNumerator(auxNumerator),
      .auxDenominator(auxDenominator), .modulatorResetDisable(modulatorResetDisable),
      .calStart(calStart), .modulatorReset(modulatorReset));
   sdc_host_model host (.sys_clk(sys_clk), .serClk(serClk), .serData(serData),
      .loadEn(loadEn));

   // Pulses last one cycle, so they are counted rather than sampled
   always @(posedge sys_clk) begin
      if (calStart === 1'b1) calCnt <= calCnt + 1;
      if (modulatorReset === 1'b1) modCnt <= modCnt + 1;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         num_errors++;
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic load(input logic [31:0] w);
      host.send_word(w);
      repeat (10) @(posedge sys_clk);
   endtask : load

   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up

   initial begin
      #(6000 * 25);
      num_errors++;
      wrap_up();
   end

   initial begin
      {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      chk({16'h0, intDivide}, 32'h0);
      // Commit path: fractions wait for word 0, 8/9 prescaler at minimum
      load({1'b0, 1'b0, 26'h0, 4'h3});
      load({4'h0, 24'h00abcd, 4'h1});
      load({14'h0005, 14'h1fff, 4'h2});
      chk({8'h0, mainNumerator}, 32'h0);
      apb(1'b0, sdc_pkg::ADDR_SHADOW1, 32'h0);
      chk(rd, {4'h0, 24'h00abcd, 4'h1});
      chk({30'h0, pready, err}, 32'h2);
      load({10'h0, 1'b1, 1'b1, 16'h004b, 4'h0});
      chk({16'h0, intDivide}, 32'h004b);
      chk({30'h0, autocalEnable, prescalerSelect}, 32'h3);
      chk({8'h0, mainNumerator}, 32'h00abcd);
      chk({18'h0, auxNumerator}, 32'h0005);
      chk({18'h0, auxDenominator}, 32'h1fff);
      chk(calCnt, 32'h1);
      chk(modCnt, 32'h1);
      $display("Test commit done");
      // Phase adjust: no calibration, modulator reset suppressed
      load({1'b0, 1'b1, 26'h0, 4'h3});
      load({4'h0, 24'h000123, 4'h1});
      chk({8'h0, mainNumerator}, 32'h00abcd);
      load({10'h0, 1'b0, 1'b0, 16'h0017, 4'h0});
      chk({31'h0, modulatorResetDisable}, 32'h1);
      chk({16'h0, intDivide}, 32'h0017);
      chk({31'h0, prescalerSelect}, 32'h0);
      chk({8'h0, mainNumerator}, 32'h000123);
      chk(calCnt, 32'h1);
      chk(modCnt, 32'h1);
      $display("Test phase adjust done");
      // Unknown select code and bus refusals
      load(32'h0000_fff4);
      chk({16'h0, intDivide}, 32'h0017);
      apb(1'b0, sdc_pkg::ADDR_LOAD_CNT, 32'h0);
      chk(rd, 32'h2);
      apb(1'b0, sdc_pkg::ADDR_STATUS, 32'h0);
      chk(rd, 32'h4);
      apb(1'b0, sdc_pkg::ADDR_SHADOW2, 32'h0);
      chk(rd, {14'h0005, 14'h1fff, 4'h2});
      apb(1'b1, 12'h000, 32'h1234_5670);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, {10'h0, 1'b0, 1'b0, 16'h0017, 4'h0});
      apb(1'b0, 12'h020, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      $display("Test select and bus done");
      wrap_up();
   end
endmodule : tb
`default_nettype wire
